// ### core/tmr_pkg.sv
// =============================================================
// Register map, field positions and timing for timer 2
package tmr_pkg;

   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W  = 16;

   // =============================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL   = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_MODE      = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_COUNT_LO  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_COUNT_HI  = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_RELOAD_LO = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_RELOAD_HI = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_INT_EN    = 3'h6;

   // =============================================================
   // Control register fields
   localparam int unsigned BIT_OVERFLOW  = 7;
   localparam int unsigned BIT_EXTERNAL  = 6;
   localparam int unsigned BIT_RX_SEL    = 5;
   localparam int unsigned BIT_TX_SEL    = 4;
   localparam int unsigned BIT_EXT_TRIG  = 3;
   localparam int unsigned BIT_RUN       = 2;
   localparam int unsigned BIT_CNT_TMR   = 1;
   localparam int unsigned BIT_CAP_RLD   = 0;

   // Mode register and interrupt enable fields
   localparam int unsigned BIT_DOWN_EN   = 0;
   localparam int unsigned BIT_TWELVE    = 1;
   localparam int unsigned BIT_T2_IE     = 0;

   // =============================================================
   // Reset values and count maximum
   localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
   localparam logic [DATA_W-1:0] RST_MODE    = 8'h00;
   localparam logic [CNT_W-1:0]  RST_COUNT   = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_RELOAD  = 16'h0000;
   localparam logic [CNT_W-1:0]  COUNT_MAX   = 16'hffff;

   // =============================================================
   // Clocks per count step
   localparam logic [3:0] DIV_MC_SIX     = 4'h6;
   localparam logic [3:0] DIV_MC_TWELVE  = 4'hc;
   localparam logic [3:0] DIV_BAUD_SIX   = 4'h1;
   localparam logic [3:0] DIV_BAUD_TWELVE = 4'h2;

   typedef enum logic [1:0] {
      TMR_MODE_CAPTURE,
      TMR_MODE_RELOAD_UP,
      TMR_MODE_UP_DOWN,
      TMR_MODE_BAUD
   } tmr_mode_t;

endpackage

// ### core/tmr_pin_edge.sv
`timescale 1ns/10ps
// =============================================================
// Samples pins and flags high-then-low as a falling edge
module tmr_pin_edge #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // Pins
   input  wire logic [WIDTH-1:0] pin_in,
   // Sampled level and edge
   output logic      [WIDTH-1:0] pin_level,
   output logic      [WIDTH-1:0] pin_fall
);

   logic [WIDTH-1:0] prev_level;

   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge ref_clk) begin
         if (sys_rst) begin
            pin_level[i]  <= 1'b1;
            prev_level[i] <= 1'b1;
            pin_fall[i]   <= 1'b0;
         end else begin
            pin_level[i]  <= pin_in[i];
            prev_level[i] <= pin_level[i];
            pin_fall[i]   <= prev_level[i] & ~pin_level[i];
         end
      end
   end

endmodule

// ### core/tmr_timer2.sv
`timescale 1ns/10ps
// Function
// - 16-bit counter, timer or event select
// - Capture, auto-reload and baud modes
// - Capture without trigger: plain count, overflow flag
// - Interrupt enable gates overflow flag request
// - Trigger falling edge captures count bytes
// - Capture sets external flag, same interrupt
// - Capture mode never reloads, keeps counting
// - Reset clears down enable; trigger sets direction
// - Up-only passing max sets flag, reloads
// - Up-only trigger edge forces reload, sets flag
// - Up-only interrupt from either flag
// - Up/down, trigger high: count up, reload
// - Up/down, trigger low: down, underflow loads max
// - Up/down external flag toggles, no interrupt
// - External flag cleared by software, or toggled off in up/down
// - Receive clock select chooses overflow source
// - Transmit clock select chooses overflow source
// - Timer ticks per machine cycle, counter pin edges
// - Run bit clear stops the counter
// - Baud rollover reloads, no flag, no interrupt
// - Baud internal ticks at oscillator or half
module tmr_timer2
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Pins
   input  wire logic              trigger_pin,
   input  wire logic              count_input_pin,
   // Serial port clock sources
   input  wire logic              timer1_overflow,
   output logic                   rx_baud_tick,
   output logic                   tx_baud_tick,
   // Interrupt request
   output logic                   t2_irq
);

   // =============================================================
   // Registers
   logic [5:0]       ctrl_cfg;
   logic             overflow_flag;
   logic             external_flag;
   logic             down_count_enable;
   logic             twelve_clock_mode;
   logic             timer2_irq_enable;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] reload_value;

   logic             rx_clock_select;
   logic             tx_clock_select;
   logic             ext_trigger_enable;
   logic             run_control;
   logic             counter_timer_select;
   logic             capture_reload_select;

   assign rx_clock_select       = ctrl_cfg[BIT_RX_SEL];
   assign tx_clock_select       = ctrl_cfg[BIT_TX_SEL];
   assign ext_trigger_enable    = ctrl_cfg[BIT_EXT_TRIG];
   assign run_control           = ctrl_cfg[BIT_RUN];
   assign counter_timer_select  = ctrl_cfg[BIT_CNT_TMR];
   assign capture_reload_select = ctrl_cfg[BIT_CAP_RLD];

   logic wr_ctrl;
   logic wr_mode;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_rld_lo;
   logic wr_rld_hi;
   logic wr_ie;

   assign wr_ctrl   = reg_wr && (reg_addr == OFS_CONTROL);
   assign wr_mode   = reg_wr && (reg_addr == OFS_MODE);
   assign wr_cnt_lo = reg_wr && (reg_addr == OFS_COUNT_LO);
   assign wr_cnt_hi = reg_wr && (reg_addr == OFS_COUNT_HI);
   assign wr_rld_lo = reg_wr && (reg_addr == OFS_RELOAD_LO);
   assign wr_rld_hi = reg_wr && (reg_addr == OFS_RELOAD_HI);
   assign wr_ie     = reg_wr && (reg_addr == OFS_INT_EN);

   // =============================================================
   // Pin sampling
   logic [1:0] pin_level;
   logic [1:0] pin_fall;
   logic       trig_level;
   logic       trig_fall;
   logic       cnt_fall;

   tmr_pin_edge #(
      .WIDTH     (2)
   ) u_pin_edge (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .pin_in    ({count_input_pin, trigger_pin}),
      .pin_level (pin_level),
      .pin_fall  (pin_fall)
   );

   assign trig_level = pin_level[0];
   assign trig_fall  = pin_fall[0];
   assign cnt_fall   = pin_fall[1];

   // =============================================================
   // Mode decode
   tmr_mode_t mode;

   always_comb begin
      if (rx_clock_select || tx_clock_select) begin
         mode = TMR_MODE_BAUD;
      end else if (capture_reload_select) begin
         mode = TMR_MODE_CAPTURE;
      end else if (down_count_enable) begin
         mode = TMR_MODE_UP_DOWN;
      end else begin
         mode = TMR_MODE_RELOAD_UP;
      end
   end

   // =============================================================
   // Step divider
   logic [3:0] div_limit;
   logic [3:0] div_cnt;
   logic       tick;

   always_comb begin
      if (mode == TMR_MODE_BAUD) begin
         div_limit = twelve_clock_mode ? DIV_BAUD_TWELVE : DIV_BAUD_SIX;
      end else begin
         div_limit = twelve_clock_mode ? DIV_MC_TWELVE : DIV_MC_SIX;
      end
   end

   assign tick = (div_cnt >= div_limit - 4'h1);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_cnt <= 4'h0;
      end else if (tick) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   logic step;

   // Timer ticks or counter edges, only while running
   assign step = run_control && (counter_timer_select ? cnt_fall : tick);

   // =============================================================
   // Count engine
   logic [CNT_W-1:0] next_count;
   logic             set_ovf;
   logic             set_ext;
   logic             tog_ext;
   logic             baud_roll;
   logic             do_capture;

   always_comb begin
      next_count = count;
      set_ovf    = 1'b0;
      set_ext    = 1'b0;
      tog_ext    = 1'b0;
      baud_roll  = 1'b0;
      do_capture = 1'b0;
      case (mode)
         TMR_MODE_CAPTURE: begin
            if (step) begin
               next_count = count + 16'h0001;
               set_ovf    = (count == COUNT_MAX);
            end
            if (ext_trigger_enable && trig_fall) begin
               do_capture = 1'b1;
               set_ext    = 1'b1;
            end
         end
         TMR_MODE_RELOAD_UP: begin
            if (step && count == COUNT_MAX) begin
               next_count = reload_value;
               set_ovf    = 1'b1;
            end else if (step) begin
               next_count = count + 16'h0001;
            end
            if (ext_trigger_enable && trig_fall) begin
               next_count = reload_value;
               set_ext    = 1'b1;
            end
         end
         TMR_MODE_UP_DOWN: begin
            if (step && trig_level) begin
               if (count == COUNT_MAX) begin
                  next_count = reload_value;
                  set_ovf    = 1'b1;
                  tog_ext    = 1'b1;
               end else begin
                  next_count = count + 16'h0001;
               end
            end else if (step) begin
               if (count == reload_value) begin
                  next_count = COUNT_MAX;
                  set_ovf    = 1'b1;
                  tog_ext    = 1'b1;
               end else begin
                  next_count = count - 16'h0001;
               end
            end
         end
         TMR_MODE_BAUD: begin
            if (step && count == COUNT_MAX) begin
               next_count = reload_value;
               baud_roll  = 1'b1;
            end else if (step) begin
               next_count = count + 16'h0001;
            end
            set_ext = ext_trigger_enable && trig_fall;
         end
         default: begin
            next_count = count;
         end
      endcase
   end

   // =============================================================
   // Counter register, software write overrides the step
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count <= RST_COUNT;
      end else begin
         count[7:0]  <= wr_cnt_lo ? reg_wdata : next_count[7:0];
         count[15:8] <= wr_cnt_hi ? reg_wdata : next_count[15:8];
      end
   end

   // Reload and capture register, capture beats software
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reload_value <= RST_RELOAD;
      end else if (do_capture) begin
         reload_value <= count;
      end else begin
         if (wr_rld_lo) begin
            reload_value[7:0] <= reg_wdata;
         end
         if (wr_rld_hi) begin
            reload_value[15:8] <= reg_wdata;
         end
      end
   end

   // =============================================================
   // Configuration registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_cfg <= RST_CONTROL[5:0];
      end else if (wr_ctrl) begin
         ctrl_cfg <= reg_wdata[5:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         down_count_enable <= RST_MODE[BIT_DOWN_EN];
         twelve_clock_mode <= RST_MODE[BIT_TWELVE];
      end else if (wr_mode) begin
         down_count_enable <= reg_wdata[BIT_DOWN_EN];
         twelve_clock_mode <= reg_wdata[BIT_TWELVE];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         timer2_irq_enable <= 1'b0;
      end else if (wr_ie) begin
         timer2_irq_enable <= reg_wdata[BIT_T2_IE];
      end
   end

   // =============================================================
   // Flags: hardware events win over a software clear
   logic next_ovf;
   logic next_ext;

   always_comb begin
      next_ovf = wr_ctrl ? reg_wdata[BIT_OVERFLOW] : overflow_flag;
      next_ovf = next_ovf | set_ovf;
      next_ext = wr_ctrl ? reg_wdata[BIT_EXTERNAL] : external_flag;
      next_ext = (next_ext ^ tog_ext) | set_ext;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         overflow_flag <= RST_CONTROL[BIT_OVERFLOW];
         external_flag <= RST_CONTROL[BIT_EXTERNAL];
      end else begin
         overflow_flag <= next_ovf;
         external_flag <= next_ext;
      end
   end

   // =============================================================
   // Interrupt and serial clock outputs
   logic ext_requests;

   assign ext_requests = external_flag && (mode != TMR_MODE_UP_DOWN);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         t2_irq <= 1'b0;
      end else begin
         t2_irq <= timer2_irq_enable && (overflow_flag || ext_requests);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rx_baud_tick <= 1'b0;
         tx_baud_tick <= 1'b0;
      end else begin
         rx_baud_tick <= rx_clock_select ? baud_roll : timer1_overflow;
         tx_baud_tick <= tx_clock_select ? baud_roll : timer1_overflow;
      end
   end

   // =============================================================
   // Read port, data one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_CONTROL:   reg_rdata <= {overflow_flag, external_flag, ctrl_cfg};
            OFS_MODE:      reg_rdata <= {6'h00, twelve_clock_mode, down_count_enable};
            OFS_COUNT_LO:  reg_rdata <= count[7:0];
            OFS_COUNT_HI:  reg_rdata <= count[15:8];
            OFS_RELOAD_LO: reg_rdata <= reload_value[7:0];
            OFS_RELOAD_HI: reg_rdata <= reload_value[15:8];
            OFS_INT_EN:    reg_rdata <= {7'h00, timer2_irq_enable};
            default:       reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // =============================================================
   // Assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_run_stop_hold: assert property (
      (!run_control && !reg_wr && !(ext_trigger_enable && trig_fall)) |=> $stable(count))
      else $error("count moved while run bit clear");

   a_capture_copy: assert property (
      (mode == TMR_MODE_CAPTURE && ext_trigger_enable && trig_fall && !reg_wr)
         |=> (reload_value == $past(count)) && external_flag)
      else $error("capture did not copy count");

   a_capture_wrap: assert property (
      (mode == TMR_MODE_CAPTURE && step && count == COUNT_MAX && !reg_wr)
         |=> overflow_flag && count == 16'h0000)
      else $error("capture mode overflow wrong");

   a_up_reload: assert property (
      (mode == TMR_MODE_RELOAD_UP && step && count == COUNT_MAX && !reg_wr && !trig_fall)
         |=> overflow_flag && count == $past(reload_value))
      else $error("up-only reload wrong");

   a_down_underflow: assert property (
      (mode == TMR_MODE_UP_DOWN && step && !trig_level && count == reload_value && !reg_wr)
         |=> count == COUNT_MAX && overflow_flag && external_flag != $past(external_flag))
      else $error("underflow did not load max");

   a_baud_no_flag: assert property (
      (mode == TMR_MODE_BAUD && step && count == COUNT_MAX && !overflow_flag && !reg_wr)
         |=> !overflow_flag ##1 (t2_irq == 1'b0 || external_flag))
      else $error("baud rollover set overflow");

   a_rx_source: assert property (
      (mode == TMR_MODE_BAUD && rx_clock_select && step && count == COUNT_MAX && !reg_wr)
         |=> rx_baud_tick)
      else $error("receive clock missed rollover");

   a_tx_timer1: assert property (
      (!tx_clock_select && timer1_overflow) |=> tx_baud_tick)
      else $error("transmit clock ignored timer 1");

   a_irq_ovf: assert property (
      (timer2_irq_enable && overflow_flag && !reg_wr) |=> t2_irq)
      else $error("overflow flag raised no request");

   a_updown_quiet: assert property (
      (mode == TMR_MODE_UP_DOWN && !overflow_flag && external_flag && !reg_wr) |=> !t2_irq)
      else $error("external flag requested in up/down");

   a_set_wins: assert property (
      (wr_ctrl && !reg_wdata[BIT_OVERFLOW] && set_ovf) |=> overflow_flag)
      else $error("software clear beat overflow");

   a_tick_six: assert property (
      (tick && div_limit == DIV_MC_SIX && !reg_wr) ##1 (!reg_wr)[*6] |-> tick)
      else $error("machine cycle tick not every six");

   c_capture: cover property (mode == TMR_MODE_CAPTURE && do_capture);
   c_up_reload: cover property (mode == TMR_MODE_RELOAD_UP && set_ovf);
   c_underflow: cover property (mode == TMR_MODE_UP_DOWN && step && !trig_level && tog_ext);
   c_baud_roll: cover property (baud_roll ##1 rx_baud_tick);

endmodule

// ### sim/tmr_far_side.sv
`timescale 1ns/10ps
// =============================================================
// Far side: trigger pin, count pin and timer 1 overflow
module tmr_far_side (
   // Clock
   input  wire logic ref_clk,
   // Pins toward the timer
   output logic      trigger_pin,
   output logic      count_input_pin,
   output logic      timer1_overflow
);
   initial begin
      trigger_pin     = 1'b1;
      count_input_pin = 1'b1;
      timer1_overflow = 1'b0;
   end

   // Pin high, low for two cycles, high again
   task automatic fall(input bit trig);
      @(posedge ref_clk);
      if (trig) begin
         trigger_pin <= 1'b0;
      end else begin
         count_input_pin <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
      trigger_pin     <= trig ? 1'b1 : trigger_pin;
      count_input_pin <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask

   // Direction level
   task automatic set_trig(input bit lvl);
      @(posedge ref_clk);
      trigger_pin <= lvl;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic t1_pulse();
      @(posedge ref_clk);
      timer1_overflow <= 1'b1;
      @(posedge ref_clk);
      timer1_overflow <= 1'b0;
   endtask
endmodule

// ### sim/timer2_capture_reload_counter_test.sv
`timescale 1ns/10ps
// =============================================================
// Self-checking bench for timer 2
module timer2_capture_reload_counter_test
   import tmr_pkg::*;
;
   logic              ref_clk;
   logic              sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              trigger_pin;
   logic              count_input_pin;
   logic              timer1_overflow;
   logic              rx_baud_tick;
   logic              tx_baud_tick;
   logic              t2_irq;
   int                err_total;
   int                total_checks;
   int                cycles;
   logic [15:0]       v;

   tmr_timer2 uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_pin(trigger_pin),
      .count_input_pin(count_input_pin), .timer1_overflow(timer1_overflow),
      .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .t2_irq(t2_irq)
   );

   tmr_far_side far (
      .ref_clk(ref_clk), .trigger_pin(trigger_pin), .count_input_pin(count_input_pin),
      .timer1_overflow(timer1_overflow)
   );

   initial ref_clk = 1'b0;
   always #20 ref_clk = ~ref_clk;

   // =============================================================
   // Bus and compare tasks
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   task automatic wr16(input logic [ADDR_W-1:0] lo, input logic [15:0] d);
      wr(lo, d[7:0]);
      wr(lo + 3'h1, d[15:8]);
   endtask

   task automatic rd16(input logic [ADDR_W-1:0] lo, output logic [15:0] d);
      rd(lo, d[7:0]);
      rd(lo + 3'h1, d[15:8]);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      v = 16'h0000;
      if (a == OFS_COUNT_LO || a == OFS_RELOAD_LO) begin
         rd16(a, v);
      end else begin
         rd(a, v[7:0]);
      end
      chk(v, exp);
   endtask

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // =============================================================
   // Scenarios
   task automatic t_reset();
      wr(3'h7, 8'hff);
      for (int a = 0; a < 8; a++) begin
         if (a != 3 && a != 5) begin
            chk_reg(a[2:0], 16'h0000);
         end
      end
   endtask

   task automatic t_reload_up();
      wr16(OFS_RELOAD_LO, 16'h1234);
      wr16(OFS_COUNT_LO, 16'hffff);
      wr(OFS_INT_EN, 8'h01);
      wr(OFS_CONTROL, 8'h06);
      far.fall(1'b0);
      chk_reg(OFS_COUNT_LO, 16'h1234);
      chk_reg(OFS_CONTROL, 16'h0086);
      chk(t2_irq, 1'b1);
      wr(OFS_CONTROL, 8'h06);
      repeat (3) @(posedge ref_clk);
      chk(t2_irq, 1'b0);
      wr(OFS_CONTROL, 8'h0e);
      wr16(OFS_COUNT_LO, 16'h0050);
      far.fall(1'b1);
      chk_reg(OFS_COUNT_LO, 16'h1234);
      chk_reg(OFS_CONTROL, 16'h004e);
      chk(t2_irq, 1'b1);
   endtask

   task automatic t_capture();
      wr(OFS_CONTROL, 8'h0f);
      wr16(OFS_COUNT_LO, 16'h00a5);
      far.fall(1'b1);
      repeat (20) @(posedge ref_clk);
      chk_reg(OFS_RELOAD_LO, 16'h00a5);
      chk_reg(OFS_CONTROL, 16'h004f);
      wr(OFS_CONTROL, 8'h0f);
      wr16(OFS_COUNT_LO, 16'hffff);
      far.fall(1'b0);
      chk_reg(OFS_COUNT_LO, 16'h0000);
      chk_reg(OFS_CONTROL, 16'h008f);
   endtask

   task automatic t_up_down();
      wr(OFS_CONTROL, 8'h06);
      wr(OFS_MODE, 8'h01);
      wr16(OFS_RELOAD_LO, 16'h0010);
      wr16(OFS_COUNT_LO, 16'h0011);
      far.set_trig(1'b0);
      far.fall(1'b0);
      chk_reg(OFS_COUNT_LO, 16'h0010);
      far.fall(1'b0);
      chk_reg(OFS_COUNT_LO, 16'hffff);
      chk_reg(OFS_CONTROL, 16'h00c6);
      wr(OFS_CONTROL, 8'h46);
      repeat (3) @(posedge ref_clk);
      chk(t2_irq, 1'b0);
      far.set_trig(1'b1);
      far.fall(1'b0);
      chk_reg(OFS_COUNT_LO, 16'h0010);
      chk_reg(OFS_CONTROL, 16'h0086);
      wr(OFS_CONTROL, 8'h02);
      far.fall(1'b0);
      chk_reg(OFS_COUNT_LO, 16'h0010);
   endtask

   task automatic t_baud();
      int ntx;
      int nrx;
      wr(OFS_MODE, 8'h00);
      wr16(OFS_RELOAD_LO, 16'hfffe);
      // Phase 0: transmit from timer 2; phase 1: receive from timer 2
      for (int p = 0; p < 2; p++) begin
         ntx = 0;
         nrx = 0;
         wr16(OFS_COUNT_LO, 16'hfffe);
         wr(OFS_CONTROL, (p != 0) ? 8'h24 : 8'h14);
         repeat (4) @(posedge ref_clk);
         fork
            repeat (20) begin
               @(negedge ref_clk);
               ntx += tx_baud_tick;
               nrx += rx_baud_tick;
            end
            repeat (3) far.t1_pulse();
         join
         chk((p != 0) ? nrx : ntx, 16'd10);
         chk((p != 0) ? ntx : nrx, 16'd3);
      end
      wr(OFS_CONTROL, 8'h00);
      chk_reg(OFS_CONTROL, 16'h0000);
      chk(t2_irq, 1'b0);
   endtask

   // =============================================================
   // Main sequence and timeout
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      err_total    = 0;
      total_checks = 0;
      cycles       = 0;
      sys_rst      = 1'b1;
      reg_addr     = 3'h0;
      reg_wdata    = 8'h00;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_reload_up();
      t_capture();
      t_up_down();
      t_baud();
      give_verdict();
   end
endmodule
